// [verilog/cpu_clock_source_switcher.sv]
// CPU clock source switcher: APB registers, glitch-free source handover, stabilization counter
//
// Contract
// R1: Reset selects 8 MHz divided by two, 09H.
// R2: Divider from bits 2..0; bit 3 one.
// R3: Software waits 10 us after high-speed bit.
// R4: High-speed bit tracks clock above 10 MHz.
// R5: Enable bit starts 40 MHz; wait 100 us.
// R6: Distribute: full rate timers, half CPU.
// R7: Select switches internal source to 40 MHz.
// R8: Fast status set once 40 MHz used.
// R9: Main pin mode bit sets oscillator pins.
// R10: Gain bit chosen by crystal frequency.
// R11: Sub pin mode bit 4; absent variants zero.
// R12: Clearing main halt starts main oscillator.
// R13: Clearing sub halt starts sub oscillator.
// R14: Stabilization status bits set progressively.
// R15: Main select makes main crystal source.
// R16: Main status set once main drives CPU.
// R17: Sub select makes sub crystal source.
// R18: Sub status set once sub drives CPU.
// R19: Software times sub oscillator stabilization.
// R20: Mode config accepts one write only.
// R21: High-speed bit may stay zero if divided.
// R22: Internal 8 MHz halt on bit 0.
// R23: Return to 8 MHz clears three bits.
// R24: Switches glitch-free; status after handover.
// R25: Counter clears halted, counts main cycles.
`timescale 1ns/1ns

module cpu_clock_source_switcher
    import clk_switch_pkg::*;
#(
    parameter bit HAS_SUB = 1'b1,
    parameter int HANDOVER_GAP = GATE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic main_crystal_osc,
    output osc_ctrl_t osc_ctrl,
    output clk_route_t clk_route
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (HANDOVER_GAP < 1 || HANDOVER_GAP > 255) begin : gap_check
        $error("HANDOVER_GAP must be 1 to 255");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum {
        ST_RUN,
        ST_GATE,
        ST_LOAD
    } hand_state_t;

    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [2:0] divider_q;
    logic main_select_q;
    logic sub_select_q;
    logic high_speed_q;
    logic fast_enable_q;
    logic fast_distribute_q;
    logic fast_select_q;
    logic mode_written_q;
    logic ext_input_q;
    logic main_pin_mode_q;
    logic sub_pin_mode_q;
    logic main_gain_q;
    logic main_halt_q;
    logic sub_halt_q;
    logic int_halt_q;
    logic [2:0] osc_sync_q;
    logic [STAB_CNT_W-1:0] stab_cnt_q;
    logic [7:0] stab_status;
    hand_state_t hand_state_q;
    clk_src_t active_src_q;
    clk_src_t target_src_q;
    clk_src_t wanted_src;
    logic gate_on_q;
    logic [7:0] gap_cnt_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] rd_byte;
    osc_ctrl_t osc_ctrl_q;
    clk_route_t clk_route_q;

    // ------------------------------------------------------------
    // APB slave: one wait state, registered answer
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_SYSTEM_CLOCK_SELECT) || (a == OFS_SPEED_MODE_CONTROL) ||
                 (a == OFS_FAST_OSC_CONTROL) || (a == OFS_OSC_MODE_CONFIG) ||
                 (a == OFS_OSC_RUN_CONTROL) || (a == OFS_STAB_COUNTER_STATUS);
    endfunction

    assign addr_ok = mapped(paddr);
    assign wr_en = psel && penable && pready_q && pwrite && addr_ok;
    assign rd_en = psel && penable && !pready_q && !pwrite;

    always_comb begin
        rd_byte = 8'h00;
        case (paddr)
            OFS_SYSTEM_CLOCK_SELECT: begin
                rd_byte[SCS_SUB_ACTIVE] = HAS_SUB && (active_src_q == SRC_SUB); // see R18
                rd_byte[SCS_SUB_SELECT] = sub_select_q;
                rd_byte[SCS_MAIN_ACTIVE] = (active_src_q == SRC_MAIN); // see R16
                rd_byte[SCS_MAIN_SELECT] = main_select_q;
                rd_byte[SCS_FIXED_ONE] = 1'b1; // see R2
                rd_byte[SCS_DIV_HIGH:SCS_DIV_LOW] = divider_q;
            end
            OFS_SPEED_MODE_CONTROL: begin
                rd_byte[SMC_HIGH_SPEED] = high_speed_q;
            end
            OFS_FAST_OSC_CONTROL: begin
                rd_byte[FOC_ACTIVE] = (active_src_q == SRC_INT40); // see R8
                rd_byte[FOC_SELECT] = fast_select_q;
                rd_byte[FOC_DISTRIBUTE] = fast_distribute_q;
                rd_byte[FOC_ENABLE] = fast_enable_q;
            end
            OFS_OSC_MODE_CONFIG: begin
                rd_byte[OMC_EXT_INPUT] = ext_input_q;
                rd_byte[OMC_MAIN_PIN_MODE] = main_pin_mode_q;
                rd_byte[OMC_SUB_PIN_MODE] = sub_pin_mode_q;
                rd_byte[OMC_MAIN_GAIN] = main_gain_q;
            end
            OFS_OSC_RUN_CONTROL: begin
                rd_byte[ORC_MAIN_HALT] = main_halt_q;
                rd_byte[ORC_SUB_HALT] = sub_halt_q;
                rd_byte[ORC_INT_HALT] = int_halt_q;
            end
            OFS_STAB_COUNTER_STATUS: begin
                rd_byte = stab_status; // see R14
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Clock select, divider and speed mode
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_q <= RST_DIVIDER; // see R1
            main_select_q <= 1'b0;
            sub_select_q <= 1'b0;
        end else if (wr_en && paddr == OFS_SYSTEM_CLOCK_SELECT) begin
            divider_q <= pwdata[SCS_DIV_HIGH:SCS_DIV_LOW]; // see R2
            main_select_q <= pwdata[SCS_MAIN_SELECT]; // see R15
            sub_select_q <= HAS_SUB && pwdata[SCS_SUB_SELECT]; // see R17
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_speed_q <= 1'b0;
        end else if (wr_en && paddr == OFS_SPEED_MODE_CONTROL) begin
            high_speed_q <= pwdata[SMC_HIGH_SPEED]; // see R4
        end
    end

    // ------------------------------------------------------------
    // 40 MHz oscillator control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_enable_q <= 1'b0;
            fast_distribute_q <= 1'b0;
            fast_select_q <= 1'b0;
        end else if (wr_en && paddr == OFS_FAST_OSC_CONTROL) begin
            fast_enable_q <= pwdata[FOC_ENABLE]; // see R5
            fast_distribute_q <= pwdata[FOC_DISTRIBUTE]; // see R6
            fast_select_q <= pwdata[FOC_SELECT]; // see R7
        end
    end

    // ------------------------------------------------------------
    // Oscillator mode configuration, write once after reset
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_written_q <= 1'b0;
            ext_input_q <= 1'b0;
            main_pin_mode_q <= 1'b0;
            sub_pin_mode_q <= 1'b0;
            main_gain_q <= 1'b0;
        end else if (wr_en && paddr == OFS_OSC_MODE_CONFIG && !mode_written_q) begin
            mode_written_q <= 1'b1; // see R20
            ext_input_q <= pwdata[OMC_EXT_INPUT];
            main_pin_mode_q <= pwdata[OMC_MAIN_PIN_MODE]; // see R9
            sub_pin_mode_q <= HAS_SUB && pwdata[OMC_SUB_PIN_MODE]; // see R11
            main_gain_q <= pwdata[OMC_MAIN_GAIN];
        end
    end

    // ------------------------------------------------------------
    // Oscillator run control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_halt_q <= RST_MAIN_HALT;
            sub_halt_q <= RST_SUB_HALT;
            int_halt_q <= RST_INT_HALT;
        end else if (wr_en && paddr == OFS_OSC_RUN_CONTROL) begin
            main_halt_q <= pwdata[ORC_MAIN_HALT]; // see R12
            sub_halt_q <= !HAS_SUB || pwdata[ORC_SUB_HALT]; // see R13
            int_halt_q <= pwdata[ORC_INT_HALT]; // see R22
        end
    end

    // ------------------------------------------------------------
    // Stabilization counter on main oscillator edges
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sync_q <= 3'h0;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], main_crystal_osc};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_cnt_q <= '0;
        end else if (main_halt_q) begin
            stab_cnt_q <= '0; // see R25
        end else if (osc_sync_q[1] && !osc_sync_q[2] && !stab_cnt_q[STAB_CNT_W-1]) begin
            stab_cnt_q <= stab_cnt_q + 1'b1; // see R25
        end
    end

    // Saturates once the top tap is reached, so every bit stays set
    assign stab_status = {
        stab_cnt_q >= (STAB_CNT_W'(1) << STAB_TAP7),
        stab_cnt_q >= (STAB_CNT_W'(1) << STAB_TAP6),
        stab_cnt_q >= (STAB_CNT_W'(1) << STAB_TAP5),
        stab_cnt_q >= (STAB_CNT_W'(1) << STAB_TAP4),
        stab_cnt_q >= (STAB_CNT_W'(1) << STAB_TAP3),
        stab_cnt_q >= (STAB_CNT_W'(1) << STAB_TAP2),
        stab_cnt_q >= (STAB_CNT_W'(1) << STAB_TAP1),
        stab_cnt_q >= (STAB_CNT_W'(1) << STAB_TAP0)
    }; // see R14

    // ------------------------------------------------------------
    // Source request and glitch-free handover
    // ------------------------------------------------------------
    always_comb begin
        if (sub_select_q) begin
            wanted_src = SRC_SUB; // see R17
        end else if (main_select_q) begin
            wanted_src = SRC_MAIN; // see R15
        end else if (fast_select_q && fast_enable_q && fast_distribute_q) begin
            wanted_src = SRC_INT40; // see R7
        end else begin
            wanted_src = SRC_INT8;
        end
    end

    // Clock is gated off for the gap, then the new source is loaded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hand_state_q <= ST_RUN;
            active_src_q <= SRC_INT8; // see R1
            target_src_q <= SRC_INT8;
            gate_on_q <= 1'b1;
            gap_cnt_q <= 8'h00;
        end else begin
            case (hand_state_q)
                ST_RUN: begin
                    if (wanted_src != active_src_q) begin
                        hand_state_q <= ST_GATE; // see R24
                        target_src_q <= wanted_src;
                        gate_on_q <= 1'b0;
                        gap_cnt_q <= 8'(HANDOVER_GAP);
                    end
                end
                ST_GATE: begin
                    if (gap_cnt_q == 8'h01) begin
                        hand_state_q <= ST_LOAD;
                        active_src_q <= target_src_q; // see R24
                    end
                    gap_cnt_q <= gap_cnt_q - 8'h01;
                end
                ST_LOAD: begin
                    hand_state_q <= ST_RUN;
                    gate_on_q <= 1'b1;
                end
                default: begin
                    hand_state_q <= ST_RUN;
                    gate_on_q <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_ctrl_q <= '{ext_input: 1'b0, main_pin_mode: 1'b0, sub_pin_mode: 1'b0, main_gain: 1'b0,
                            main_halt: RST_MAIN_HALT, sub_halt: RST_SUB_HALT, int_halt: RST_INT_HALT,
                            fast_enable: 1'b0};
        end else begin
            osc_ctrl_q.ext_input <= ext_input_q;
            osc_ctrl_q.main_pin_mode <= main_pin_mode_q; // see R9
            osc_ctrl_q.sub_pin_mode <= sub_pin_mode_q; // see R11
            osc_ctrl_q.main_gain <= main_gain_q;
            osc_ctrl_q.main_halt <= main_halt_q; // see R12
            osc_ctrl_q.sub_halt <= sub_halt_q; // see R13
            osc_ctrl_q.int_halt <= int_halt_q; // see R22
            osc_ctrl_q.fast_enable <= fast_enable_q; // see R5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_route_q <= '{src: SRC_INT8, divider: RST_DIVIDER, gate_on: 1'b1, timer_full_rate: 1'b0,
                             cpu_half_rate: 1'b0, high_speed: 1'b0};
        end else begin
            clk_route_q.src <= active_src_q;
            clk_route_q.divider <= divider_q; // see R2
            clk_route_q.gate_on <= gate_on_q; // see R24
            clk_route_q.timer_full_rate <= fast_distribute_q && fast_enable_q; // see R6
            clk_route_q.cpu_half_rate <= fast_distribute_q && fast_enable_q; // see R6
            clk_route_q.high_speed <= high_speed_q; // see R4
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign osc_ctrl = osc_ctrl_q;
    assign clk_route = clk_route_q;

endmodule

// [verilog/clk_switch_pkg.sv]
// Constants and types for the CPU clock source switcher
package clk_switch_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SYSTEM_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] OFS_SPEED_MODE_CONTROL = 8'h04;
    localparam logic [7:0] OFS_FAST_OSC_CONTROL = 8'h08;
    localparam logic [7:0] OFS_OSC_MODE_CONFIG = 8'h0c;
    localparam logic [7:0] OFS_OSC_RUN_CONTROL = 8'h10;
    localparam logic [7:0] OFS_STAB_COUNTER_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // system_clock_select
    localparam int SCS_SUB_ACTIVE = 7;
    localparam int SCS_SUB_SELECT = 6;
    localparam int SCS_MAIN_ACTIVE = 5;
    localparam int SCS_MAIN_SELECT = 4;
    localparam int SCS_FIXED_ONE = 3;
    localparam int SCS_DIV_HIGH = 2;
    localparam int SCS_DIV_LOW = 0;
    // speed_mode_control
    localparam int SMC_HIGH_SPEED = 0;
    // fast_osc_control
    localparam int FOC_ACTIVE = 3;
    localparam int FOC_SELECT = 2;
    localparam int FOC_DISTRIBUTE = 1;
    localparam int FOC_ENABLE = 0;
    // osc_mode_config
    localparam int OMC_EXT_INPUT = 7;
    localparam int OMC_MAIN_PIN_MODE = 6;
    localparam int OMC_SUB_PIN_MODE = 4;
    localparam int OMC_MAIN_GAIN = 0;
    // osc_run_control
    localparam int ORC_MAIN_HALT = 7;
    localparam int ORC_SUB_HALT = 6;
    localparam int ORC_INT_HALT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_DIVIDER = 3'h1;
    localparam logic RST_MAIN_HALT = 1'b1;
    localparam logic RST_SUB_HALT = 1'b1;
    localparam logic RST_INT_HALT = 1'b0;

    // ------------------------------------------------------------
    // Stabilization counter: status bit 7 down to 0 set at 2**STAB_TAP7 down to 2**STAB_TAP0 cycles
    // ------------------------------------------------------------
    localparam int STAB_CNT_W = 19;
    localparam int STAB_TAP7 = 8;
    localparam int STAB_TAP6 = 9;
    localparam int STAB_TAP5 = 10;
    localparam int STAB_TAP4 = 11;
    localparam int STAB_TAP3 = 13;
    localparam int STAB_TAP2 = 15;
    localparam int STAB_TAP1 = 17;
    localparam int STAB_TAP0 = 18;

    // ------------------------------------------------------------
    // Handover timing
    // ------------------------------------------------------------
    localparam int GATE_TIME_NS = 100;
    localparam int PCLK_PERIOD_NS = 50;
    localparam int GATE_CYCLES = (GATE_TIME_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_INT8,
        SRC_INT40,
        SRC_MAIN,
        SRC_SUB
    } clk_src_t;

    typedef struct packed {
        logic ext_input;
        logic main_pin_mode;
        logic sub_pin_mode;
        logic main_gain;
        logic main_halt;
        logic sub_halt;
        logic int_halt;
        logic fast_enable;
    } osc_ctrl_t;

    typedef struct packed {
        clk_src_t src;
        logic [2:0] divider;
        logic gate_on;
        logic timer_full_rate;
        logic cpu_half_rate;
        logic high_speed;
    } clk_route_t;

endpackage

// [testbench/cpu_clock_source_switcher_chk.sv]
// Port-level assertion checker for the CPU clock source switcher
`timescale 1ns/1ns

module cpu_clock_source_switcher_chk
    import clk_switch_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire osc_ctrl_t osc_ctrl,
    input wire clk_route_t clk_route
);
    localparam int GAP_MAX = 300;
    logic [1:0] mode_age_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Cycles since the first mode write, saturating
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_age_q <= 2'h0;
        end else if (mode_age_q != 2'h0 || (pready && pwrite && paddr == OFS_OSC_MODE_CONFIG)) begin
            mode_age_q <= (mode_age_q == 2'h3) ? 2'h3 : mode_age_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_wr(logic [7:0] a);
        pready && pwrite && !pslverr && paddr == a;
    endsequence

    sequence s_gap_close;
        !clk_route.gate_on ##1 clk_route.gate_on;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("late pready");
    a_ready_single: assert property (pready |=> !pready)
        else $error("long pready");
    a_err_unmapped: assert property (pready && paddr > OFS_STAB_COUNTER_STATUS |-> pslverr)
        else $error("no pslverr");
    a_err_mapped: assert property (pslverr |-> pready && paddr > OFS_STAB_COUNTER_STATUS)
        else $error("bad pslverr");
    a_divider_follow: assert property (s_wr(OFS_SYSTEM_CLOCK_SELECT) |-> ##2
        clk_route.divider == $past(pwdata[2:0], 2)) else $error("divider");
    a_speed_follow: assert property (s_wr(OFS_SPEED_MODE_CONTROL) |-> ##2
        clk_route.high_speed == $past(pwdata[0], 2)) else $error("speed bit");
    a_fast_rates: assert property (s_wr(OFS_FAST_OSC_CONTROL) |-> ##2
        osc_ctrl.fast_enable == $past(pwdata[0], 2) && clk_route.timer_full_rate == &$past(pwdata[1:0], 2))
        else $error("fast ctrl");
    a_halt_follow: assert property (s_wr(OFS_OSC_RUN_CONTROL) |-> ##2
        osc_ctrl.main_halt == $past(pwdata[7], 2) && osc_ctrl.int_halt == $past(pwdata[0], 2)) else $error("halt bits");
    a_mode_once: assert property (mode_age_q == 2'h3 |->
        $stable({osc_ctrl.ext_input, osc_ctrl.main_pin_mode, osc_ctrl.sub_pin_mode, osc_ctrl.main_gain}))
        else $error("mode rewritten");
    a_src_in_gap: assert property (!$stable(clk_route.src) |-> s_gap_close)
        else $error("src outside gap");
    a_gap_bounded: assert property ($fell(clk_route.gate_on) |-> ##[1:GAP_MAX] clk_route.gate_on)
        else $error("gap open");
    a_read_fixed: assert property (pready && !pwrite && paddr == OFS_SYSTEM_CLOCK_SELECT |->
        prdata[3] && prdata[31:8] == 24'h0) else $error("fixed bits");
endmodule

// [testbench/tb.sv]
// Self-checking testbench for the CPU clock source switcher
`timescale 1ns/1ns

module tb;
    import clk_switch_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic main_crystal_osc = 1'b0;
    logic [1:0] osc_div_q = 2'h0;
    osc_ctrl_t osc_ctrl;
    clk_route_t clk_route;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h21b64388;
    logic [31:0] rd;
    logic [7:0] reg_addr [6] = '{OFS_SYSTEM_CLOCK_SELECT, OFS_SPEED_MODE_CONTROL, OFS_FAST_OSC_CONTROL,
        OFS_OSC_MODE_CONFIG, OFS_OSC_RUN_CONTROL, OFS_STAB_COUNTER_STATUS};
    logic [7:0] reg_rst [6] = '{8'h09, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00};

    cpu_clock_source_switcher cpu_clock_source_switcher_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .main_crystal_osc(main_crystal_osc), .osc_ctrl(osc_ctrl), .clk_route(clk_route));

    always #25 pclk = ~pclk;

    // ------------------------------------------------------------
    // Main crystal at one sixth of pclk
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        osc_div_q <= (osc_div_q == 2'h2) ? 2'h0 : osc_div_q + 2'h1;
        if (osc_div_q == 2'h2) begin
            main_crystal_osc <= ~main_crystal_osc;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    // Clock select image
    function automatic logic [31:0] exp_sys(logic [1:0] sel, logic [1:0] act, logic [2:0] div);
        return {24'h0, act[1], sel[1], act[0], sel[0], 1'b1, div};
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("cmp %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic exp_err = 1'b0);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        check("err", 32'(pslverr), 32'(exp_err));
        psel <= 1'b0;
        penable <= 1'b0;
        // Registered outputs settle one edge after the write lands
        repeat (2) @(negedge pclk);
    endtask

    task automatic poll(logic [7:0] a, logic [31:0] mask, logic [31:0] want);
        int n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rd & mask) !== want && n < 3000);
        check("poll", rd & mask, want);
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0] div;
        int t0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, reg_addr[i], 32'h0);
            check("reset", rd, {24'h0, reg_rst[i]});
        end
        check("route", {23'h0, clk_route}, {23'h0, SRC_INT8, 3'h1, 4'b1000});
        check("osc", {24'h0, osc_ctrl}, 32'h0c);
        apb(1'b0, 8'h18, 32'h0, 1'b1);
        apb(1'b1, 8'h3c, 32'hff, 1'b1);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            div = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : seed[2:0];
            apb(1'b1, OFS_SYSTEM_CLOCK_SELECT, exp_sys(2'b00, 2'b00, div));
            apb(1'b1, OFS_SPEED_MODE_CONTROL, 32'(seed[3]));
            apb(1'b0, OFS_SYSTEM_CLOCK_SELECT, 32'h0);
            check("sel", rd, exp_sys(2'b00, 2'b00, div));
            check("div", 32'(clk_route.divider), 32'(div));
            check("speed", 32'(clk_route.high_speed), 32'(seed[3]));
        end
        $display("divider test done");
        apb(1'b1, OFS_SPEED_MODE_CONTROL, 32'h1);
        apb(1'b1, OFS_FAST_OSC_CONTROL, 32'h1);
        check("fen", 32'(osc_ctrl.fast_enable), 32'h1);
        apb(1'b1, OFS_FAST_OSC_CONTROL, 32'h3);
        check("rates", {30'h0, clk_route.timer_full_rate, clk_route.cpu_half_rate}, 32'h3);
        apb(1'b1, OFS_FAST_OSC_CONTROL, 32'h7);
        poll(OFS_FAST_OSC_CONTROL, 32'h08, 32'h08);
        check("src", 32'(clk_route.src), 32'(SRC_INT40));
        check("fast", rd, 32'h0f);
        apb(1'b1, OFS_FAST_OSC_CONTROL, 32'h0);
        poll(OFS_FAST_OSC_CONTROL, 32'h08, 32'h0);
        check("src", 32'(clk_route.src), 32'(SRC_INT8));
        $display("fast test done");
        apb(1'b1, OFS_OSC_MODE_CONFIG, 32'h50);
        apb(1'b1, OFS_OSC_MODE_CONFIG, 32'h81);
        apb(1'b0, OFS_OSC_MODE_CONFIG, 32'h0);
        check("mode", rd, 32'h50);
        check("pins", {24'h0, osc_ctrl}, 32'h6c);
        apb(1'b0, OFS_STAB_COUNTER_STATUS, 32'h0);
        check("stab", rd, 32'h0);
        apb(1'b1, OFS_OSC_RUN_CONTROL, 32'h40);
        t0 = cyc;
        check("osc", {24'h0, osc_ctrl}, 32'h64);
        poll(OFS_STAB_COUNTER_STATUS, 32'hff, 32'he0);
        check("stab time", 32'((cyc - t0) >= 6100), 32'h1);
        apb(1'b1, OFS_SYSTEM_CLOCK_SELECT, exp_sys(2'b01, 2'b00, 3'h0));
        poll(OFS_SYSTEM_CLOCK_SELECT, 32'h20, 32'h20);
        check("src", 32'(clk_route.src), 32'(SRC_MAIN));
        check("sel", rd, exp_sys(2'b01, 2'b01, 3'h0));
        $display("main test done");
        apb(1'b1, OFS_OSC_RUN_CONTROL, 32'h00);
        check("osc", {24'h0, osc_ctrl}, 32'h60);
        apb(1'b1, OFS_SYSTEM_CLOCK_SELECT, exp_sys(2'b11, 2'b00, 3'h0));
        poll(OFS_SYSTEM_CLOCK_SELECT, 32'h80, 32'h80);
        check("src", 32'(clk_route.src), 32'(SRC_SUB));
        check("sel", rd, exp_sys(2'b11, 2'b10, 3'h0));
        apb(1'b1, OFS_SYSTEM_CLOCK_SELECT, 32'h09);
        poll(OFS_SYSTEM_CLOCK_SELECT, 32'hff, 32'h09);
        check("src", 32'(clk_route.src), 32'(SRC_INT8));
        apb(1'b1, OFS_OSC_RUN_CONTROL, 32'hc1);
        check("osc", {24'h0, osc_ctrl}, 32'h6e);
        apb(1'b0, OFS_STAB_COUNTER_STATUS, 32'h0);
        check("stab", rd, 32'h0);
        $display("sub test done");
        conclude();
    end
endmodule

bind cpu_clock_source_switcher cpu_clock_source_switcher_chk chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_ctrl(osc_ctrl), .clk_route(clk_route));
